// >>> hdl/run_sync_pixel_advance.sv
// run start, gate and pixel advance control of one module
`timescale 1ns/1ns
`include "run_sync_regs.svh"
module run_sync_pixel_advance #(
    parameter int PIXEL_WIDTH = 32,
    parameter int DIV_WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic run_ready_line_in,
    output logic run_ready_line_out,
    output logic run_ready_line_oe,
    input wire logic fp_run_in,
    output logic fp_run_out,
    output logic fp_run_oe,
    input wire logic fp_gate_in,
    input wire logic bp_gate_in,
    output logic bp_gate_out,
    output logic bp_gate_oe,
    input wire logic fp_pclk_in,
    input wire logic bp_pclk_in,
    output logic bp_pclk_out,
    output logic bp_pclk_oe,
    output logic led_run_master,
    output logic led_gate_master,
    output logic led_pclk_master,
    output logic acquire,
    output logic pixel_advance,
    output run_sync_pkg::run_state_type run_state
);
    import run_sync_pkg::*;

    // ****************************************
    // registers and synchronisers
    // ****************************************
    logic [`CTRL_WIDTH-1:0] ctrl_reg;
    logic [DIV_WIDTH-1:0] div_reg;
    logic [PIXEL_WIDTH-1:0] pixel_reg;
    logic [DIV_WIDTH-1:0] pclk_cnt_reg;
    run_state_type state_reg;
    run_state_type state_next;
    logic [`SYNC_WIDTH-1:0] meta_reg;
    logic [`SYNC_WIDTH-1:0] sync_reg;
    logic gate_prev_reg;
    logic pclk_prev_reg;
    logic bp_from_fp_reg;
    logic start_pulse;
    logic stop_pulse;
    logic mapping;
    logic polarity;
    logic ignore;
    logic clk_adv;
    logic edge_start;
    logic ready_s;
    logic fp_run_s;
    logic gate_s;
    logic pclk_s;
    logic gate_acq;
    logic gate_trail;
    logic gate_release;
    logic pclk_rise;
    logic [DIV_WIDTH-1:0] div_eff;

    assign start_pulse = wr && addr == `CTRL_OFFSET && wdata[`CTRL_START_BIT];
    assign stop_pulse = wr && addr == `CTRL_OFFSET && wdata[`CTRL_STOP_BIT];
    assign mapping = ctrl_reg[`CTRL_MAPPING_BIT];
    assign polarity = ctrl_reg[`CTRL_POLARITY_BIT];
    assign ignore = ctrl_reg[`CTRL_IGNORE_BIT] && mapping;
    assign clk_adv = ctrl_reg[`CTRL_CLKADV_BIT] && mapping;
    assign edge_start = ctrl_reg[`CTRL_EDGESTART_BIT] && clk_adv;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= {run_ready_line_in, fp_run_in, fp_gate_in, bp_gate_in, fp_pclk_in, bp_pclk_in};
            sync_reg <= meta_reg;
        end
    end

    assign ready_s = sync_reg[5];
    assign fp_run_s = sync_reg[4];
    // master uses its own front input, others the backplane
    assign gate_s = ctrl_reg[`CTRL_GATEMASTER_BIT] ? sync_reg[3] : sync_reg[2];
    assign pclk_s = ctrl_reg[`CTRL_CLKMASTER_BIT] ? sync_reg[1] : sync_reg[0];

    // polarity selects which gate level halts acquisition
    assign gate_acq = polarity ? !gate_s : gate_s;
    // trailing edge is acquiring-to-halting on the interpreted gate
    assign gate_trail = gate_prev_reg && !gate_acq;
    assign gate_release = !gate_prev_reg && gate_acq;
    assign pclk_rise = !pclk_prev_reg && pclk_s;
    // a divider of zero would never advance, so it behaves as one
    assign div_eff = (div_reg == '0) ? DIV_WIDTH'(1) : div_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            gate_prev_reg <= 1'b0;
            pclk_prev_reg <= 1'b0;
        end
        else
        begin
            gate_prev_reg <= gate_acq;
            pclk_prev_reg <= pclk_s;
        end
    end

    // ****************************************
    // register bus
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_reg <= `CTRL_RESET;
            div_reg <= `DIV_RESET;
        end
        else if (wr)
        begin
            if (addr == `CTRL_OFFSET)
                ctrl_reg <= {wdata[`CTRL_WIDTH-1:2], 2'b00};
            if (addr == `DIV_OFFSET)
                div_reg <= wdata[DIV_WIDTH-1:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rdata <= '0;
        else if (rd)
        begin
            unique case (addr)
                `CTRL_OFFSET: rdata <= 32'(ctrl_reg);
                `DIV_OFFSET: rdata <= 32'(div_reg);
                `STATUS_OFFSET: rdata <= {24'h000000, gate_s, ready_s, acquire, 1'b0, state_reg};
                `PIXEL_OFFSET: rdata <= 32'(pixel_reg);
                default: rdata <= '0;
            endcase
        end
        else
            rdata <= '0;
    end

    // ****************************************
    // run state
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                // only the own start command arms the run
                if (start_pulse)
                    state_next = ST_ARMED;
            ST_ARMED:
                // ready rising means every module has started
                if (ready_s)
                    state_next = ST_WAIT;
            ST_WAIT:
                // first clock edge or first gate release
                if (edge_start ? pclk_rise : gate_acq)
                    state_next = ST_RUN;
            ST_RUN:
                state_next = ST_RUN;
        endcase
        if (stop_pulse)
            state_next = ST_IDLE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            run_state <= ST_IDLE;
        else
            run_state <= state_next;
    end

    // halting gate stops events and counters unless ignored or edge start is set
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            acquire <= 1'b0;
        else
            acquire <= state_reg == ST_RUN && (ignore || edge_start || gate_acq);
    end

    // ****************************************
    // pixel advance
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (rst || state_reg != ST_RUN)
            pclk_cnt_reg <= '0;
        // count rising edges up to N
        else if (clk_adv && pclk_rise)
            pclk_cnt_reg <= (pclk_cnt_reg == div_eff - DIV_WIDTH'(1)) ? '0 : pclk_cnt_reg + DIV_WIDTH'(1);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || state_reg != ST_RUN || !mapping)
            pixel_advance <= 1'b0;
        else if (clk_adv)
            pixel_advance <= pclk_rise && pclk_cnt_reg == div_eff - DIV_WIDTH'(1);
        else
            // advance on the trailing gate edge
            pixel_advance <= gate_trail;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || start_pulse)
            pixel_reg <= '0;
        else if (pixel_advance)
            pixel_reg <= pixel_reg + PIXEL_WIDTH'(1);
    end

    // ****************************************
    // backplane and front panel drivers
    // ****************************************
    // pull the wired-OR line low until started
    // master joins the line with its front connector
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            run_ready_line_oe <= 1'b1;
            fp_run_oe <= 1'b0;
            bp_from_fp_reg <= 1'b0;
            run_ready_line_out <= 1'b0;
            fp_run_out <= 1'b0;
        end
        else
        begin
            // open-drain: the driven level is always low, only the enable moves
            run_ready_line_out <= 1'b0;
            fp_run_out <= 1'b0;
            // loop guard: a low coming in from the front is not echoed back out
            bp_from_fp_reg <= ctrl_reg[`CTRL_RUNMASTER_BIT] && !fp_run_s && !fp_run_oe;
            run_ready_line_oe <= state_reg == ST_IDLE || bp_from_fp_reg;
            fp_run_oe <= ctrl_reg[`CTRL_RUNMASTER_BIT] && !ready_s && !bp_from_fp_reg;
        end
    end

    // master drives its front signals onto the backplane
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bp_gate_oe <= 1'b0;
            bp_gate_out <= 1'b0;
            bp_pclk_oe <= 1'b0;
            bp_pclk_out <= 1'b0;
        end
        else
        begin
            bp_gate_oe <= ctrl_reg[`CTRL_GATEMASTER_BIT];
            bp_gate_out <= sync_reg[3];
            bp_pclk_oe <= ctrl_reg[`CTRL_CLKMASTER_BIT];
            bp_pclk_out <= sync_reg[1];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            led_run_master <= 1'b0;
            led_gate_master <= 1'b0;
            led_pclk_master <= 1'b0;
        end
        else
        begin
            led_run_master <= ctrl_reg[`CTRL_RUNMASTER_BIT];
            led_gate_master <= ctrl_reg[`CTRL_GATEMASTER_BIT];
            led_pclk_master <= ctrl_reg[`CTRL_CLKMASTER_BIT];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_waiting;
        state_reg == ST_WAIT;
    endsequence
    sequence s_running_gated;
        state_reg == ST_RUN && !ignore && !edge_start;
    endsequence

    a_idle_holdoff: assert property (state_reg == ST_IDLE ##1 state_reg == ST_IDLE |-> run_ready_line_oe)
        else $error("idle module not holding run line low");
    a_acq_only_run: assert property (acquire |-> $past(state_reg) == ST_RUN)
        else $error("acquiring outside a run");
    a_ready_start: assert property (state_reg == ST_ARMED && ready_s && !stop_pulse |=> s_waiting)
        else $error("ready line did not start the run");
    a_gate_halt: assert property (s_running_gated and !gate_acq |=> !acquire)
        else $error("halting gate did not stop acquisition");
    a_gate_polarity: assert property (s_running_gated and polarity && gate_s |=> !acquire)
        else $error("inverted gate high did not halt");
    a_gate_advance: assert property (state_reg == ST_RUN && mapping && !clk_adv && gate_trail |=> pixel_advance)
        else $error("trailing gate edge missed pixel advance");
    a_ignore_acq: assert property ((state_reg == ST_RUN && ignore) [*2] |-> acquire)
        else $error("gate ignore halted acquisition");
    a_first_release: assert property (s_waiting |=> !acquire)
        else $error("acquired before first release");
    a_clock_div: assert property (state_reg == ST_RUN && clk_adv && !pixel_advance ##1 pixel_advance |-> $past(pclk_rise))
        else $error("pixel advance without clock edge");
    a_edge_start: assert property (s_waiting and edge_start && pclk_rise && !stop_pulse |=> state_reg == ST_RUN)
        else $error("first clock edge did not start run");
    a_master_drive: assert property (ctrl_reg[`CTRL_GATEMASTER_BIT] |=> bp_gate_oe && led_gate_master)
        else $error("gate master not driving backplane");
    a_slave_quiet: assert property (!ctrl_reg[`CTRL_CLKMASTER_BIT] |=> !bp_pclk_oe && !led_pclk_master)
        else $error("non-master driving backplane clock");
endmodule

// >>> inc/run_sync_pkg.sv
// types shared by the run synchronisation logic
package run_sync_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARMED = 4'h2,
        ST_WAIT = 4'h4,
        ST_RUN = 4'h8
    } run_state_type;
endpackage

// >>> inc/run_sync_regs.svh
// register map and bit positions of the run, gate and pixel-advance block
// Functional notes
// - run held off until start and all ready
// - master drives front input onto backplane
// - non-masters take signals from backplane
// - master lights indicator per mastered function
// - run-ready master bridges line to front connector
// - ready rising means all started together
// - normal mode halting gate stops counters
// - polarity setting inverts gate halting level
// - gate trailing edge advances pixel
// - inverted polarity advances on rising edge
// - gate ignore advances pixel, keeps acquiring
// - gate ignore still waits first release
// - clock advance every N rising edges
// - start on first clock edge or gate
`ifndef RUN_SYNC_REGS_SVH
`define RUN_SYNC_REGS_SVH
`define CTRL_OFFSET 8'h00
`define DIV_OFFSET 8'h04
`define STATUS_OFFSET 8'h08
`define PIXEL_OFFSET 8'h0c
`define CTRL_START_BIT 0
`define CTRL_STOP_BIT 1
`define CTRL_MAPPING_BIT 2
`define CTRL_POLARITY_BIT 3
`define CTRL_IGNORE_BIT 4
`define CTRL_CLKADV_BIT 5
`define CTRL_EDGESTART_BIT 6
`define CTRL_RUNMASTER_BIT 7
`define CTRL_GATEMASTER_BIT 8
`define CTRL_CLKMASTER_BIT 9
`define CTRL_WIDTH 10
`define CTRL_RESET 10'h000
`define DIV_RESET 16'h0001
`define SYNC_WIDTH 6
`endif

// >>> verification/run_peer_model.sv
// peer modules and user timing hardware beyond the backplane
`timescale 1ns/1ns
module run_peer_model (
    input wire logic run_line,
    output logic hold,
    output logic gate,
    output logic pclk
);
    initial
    begin
        hold = 1'b1;
        gate = 1'b0;
        pclk = 1'b0;
    end
    task automatic set_hold(input logic v);
        hold = v;
    endtask
    // caller keeps gate halting until ready
    task automatic set_gate(input logic v);
        gate = v;
    endtask
    task automatic pulse_clk(input int n);
        repeat (50) if (!run_line) #10;
        repeat (n)
        begin
            #80 pclk = 1'b1;
            #80 pclk = 1'b0;
        end
    endtask
endmodule

// >>> verification/run_sync_pixel_advance_tb.sv
// self-checking bench of the run, gate and pixel-advance block
`timescale 1ns/1ns
`include "run_sync_regs.svh"
module run_sync_pixel_advance_tb;
    import run_sync_pkg::*;
    typedef struct {logic [9:0] cfg; logic halt; logic [31:0] pix; logic acq;} row_type;
    logic ref_clk, rst, wr, rd, fp_gate, rl_oe, rl_out, fr_out, fr_oe, bg_out, bg_oe;
    logic bp_out, bp_oe, led_r, led_g, led_p, acquire, pixel_advance, hold, gate, pclk;
    logic fp_run, fp_pclk;
    int pulses = 0;
    wire line_w = ~(rl_oe | hold);
    wire bp_gate_w = bg_oe ? bg_out : gate;
    wire bp_pclk_w = bp_oe ? bp_out : pclk;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    run_state_type run_state;
    int errors = 0;
    int samples_checked = 0;
    row_type rows [5] = '{'{10'h000, 1'b0, 32'h0, 1'b0}, '{10'h004, 1'b0, 32'h2, 1'b0},
        '{10'h00c, 1'b1, 32'h2, 1'b0}, '{10'h014, 1'b0, 32'h2, 1'b1}, '{10'h01c, 1'b1, 32'h2, 1'b1}};
    run_sync_pixel_advance u_run_sync_pixel_advance (
        .ref_clk(ref_clk),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .run_ready_line_in(line_w),
        .run_ready_line_out(rl_out),
        .run_ready_line_oe(rl_oe),
        .fp_run_in(fp_run),
        .fp_run_out(fr_out),
        .fp_run_oe(fr_oe),
        .fp_gate_in(fp_gate),
        .bp_gate_in(bp_gate_w),
        .bp_gate_out(bg_out),
        .bp_gate_oe(bg_oe),
        .fp_pclk_in(fp_pclk),
        .bp_pclk_in(bp_pclk_w),
        .bp_pclk_out(bp_out),
        .bp_pclk_oe(bp_oe),
        .led_run_master(led_r),
        .led_gate_master(led_g),
        .led_pclk_master(led_p),
        .acquire(acquire),
        .pixel_advance(pixel_advance),
        .run_state(run_state)
    );
    run_peer_model u_run_peer_model (
        .run_line(line_w),
        .hold(hold),
        .gate(gate),
        .pclk(pclk)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // count advance pulses seen at the pin, cleared by each start
    always @(posedge ref_clk)
        if (pixel_advance === 1'b1)
            pulses <= pulses + 1;
    // ****************
    // tasks
    // ****************
    task automatic chk_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // stop first so every case begins idle
    task automatic start(input logic [9:0] cfg);
        wr_reg(`CTRL_OFFSET, 32'h2);
        pulses = 0;
        wr_reg(`CTRL_OFFSET, {22'h0, cfg});
        wr_reg(`CTRL_OFFSET, {22'h0, cfg} | 32'h1);
    endtask
    task automatic clk_case(input logic es);
        wr_reg(`DIV_OFFSET, 32'h3);
        u_run_peer_model.set_gate(1'b0);
        u_run_peer_model.set_hold(1'b1);
        start(es ? 10'h064 : 10'h024);
        u_run_peer_model.set_hold(1'b0);
        wait_cyc(8);
        if (!es) u_run_peer_model.set_gate(1'b1);
        wait_cyc(8);
        chk_bit("pre_clk", ~es, acquire);
        u_run_peer_model.pulse_clk(es ? 7 : 6);
        wait_cyc(8);
        chk_bit("clk_acq", 1'b1, acquire);
        rd_reg(`PIXEL_OFFSET);
        chk_word("clk_pixel", 32'h2, d);
        $display("clock advance case %0d done", es);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial
    begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        fp_gate = 1'b0;
        fp_run = 1'b1;
        fp_pclk = 1'b0;
        wait_cyc(2);
        rst <= 1'b0;
        wait_cyc(1);
        chk_bit("idle", 1'b1, run_state === ST_IDLE);
        chk_bit("idle_oe", 1'b1, rl_oe);
        rd_reg(`DIV_OFFSET);
        chk_word("div", 32'h1, d);
        rd_reg(8'h10);
        chk_word("unmapped", 32'h0, d);
        foreach (rows[i])
        begin
            u_run_peer_model.set_gate(rows[i].halt);
            u_run_peer_model.set_hold(1'b1);
            start(rows[i].cfg);
            wait_cyc(8);
            chk_bit("armed_oe", 1'b0, rl_oe);
            chk_bit("armed", 1'b1, run_state === ST_ARMED);
            u_run_peer_model.set_hold(1'b0);
            wait_cyc(8);
            chk_bit("held", 1'b0, acquire);
            repeat (2)
            begin
                u_run_peer_model.set_gate(~rows[i].halt);
                wait_cyc(8);
                chk_bit("acq", 1'b1, acquire);
                u_run_peer_model.set_gate(rows[i].halt);
                wait_cyc(8);
                chk_bit("halt", rows[i].acq, acquire);
            end
            rd_reg(`PIXEL_OFFSET);
            chk_word("pixel", rows[i].pix, d);
            chk_word("pulses", rows[i].pix, pulses);
            $display("gate row %0d done", i);
        end
        clk_case(1'b0);
        clk_case(1'b1);
        u_run_peer_model.set_hold(1'b1);
        start(10'h380);
        fp_gate <= 1'b1;
        wait_cyc(6);
        chk_bit("led_run", 1'b1, led_r);
        chk_bit("led_gate", 1'b1, led_g & led_p);
        chk_bit("gate_fwd", 1'b1, bg_out & bg_oe);
        chk_bit("run_front", 1'b1, fr_oe);
        fp_gate <= 1'b0;
        u_run_peer_model.set_hold(1'b0);
        wait_cyc(6);
        chk_bit("gate_low", 1'b0, bg_out);
        chk_bit("run_free", 1'b0, fr_oe);
        chk_bit("line_level", 1'b0, rl_out | fr_out);
        rd_reg(`STATUS_OFFSET);
        chk_word("status", 32'h44, d);
        wr_reg(`CTRL_OFFSET, 32'h2);
        wait_cyc(4);
        chk_bit("slave", 1'b0, led_g | bg_oe | bp_oe);
        $display("master case done");
        complete_run();
    end
    initial
    begin
        #200000;
        errors++;
        complete_run();
    end
endmodule
